// File: include/ussc_pkg.sv
// Behaviour
// R1: Phase bit picks change-first or capture-first
// R2: Two-wire mode bit enables I2C operation
// R3: Start enable gates start flag interrupt request
// R4: Count enable gates completion flag interrupt request
// R5: Arbitration-lost bit reads one after loss
// R6: Stop flag sets; nonzero count load clears
// R7: Polarity bit sets serial clock idle level
// R8: Width bit selects 8 or 16 bit shifting
// R9: Autoclear control keeps flag on count load
// R10: Count field holds bits left to shift
// R11: Completion flag sets when count reaches zero
// R12: Start flag sets on START; software clears
// R13: Arbitration loss also drops data drive enable
// R14: Release bit frees clock; START clears it
// R15: Divider code divides source by power two
// R16: Source code selects one of shift clocks
package ussc_pkg;
	typedef logic [7:0] addr_t;
	typedef logic [31:0] word_t;
	typedef logic [3:0] strb_t;
	typedef logic [1:0] resp_t;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam addr_t OFF_CTRL = 8'h00;
	localparam addr_t OFF_CLKC = 8'h04;
	localparam addr_t OFF_CNT = 8'h08;
	localparam addr_t OFF_SR = 8'h0c;
	localparam addr_t OFF_SRH = 8'h10;
	localparam addr_t OFF_AUX = 8'h14;

	// ****************************************
	// Field positions
	// ****************************************
	localparam int CF_PHASE = 7;
	localparam int CF_I2C = 6;
	localparam int CF_STTIE = 5;
	localparam int CF_IE = 4;
	localparam int CF_AL = 3;
	localparam int CF_STP = 2;
	localparam int CF_STT = 1;
	localparam int CF_IFG = 0;
	localparam int CK_DIV_LSB = 5;
	localparam int CK_SEL_LSB = 2;
	localparam int CK_POL = 1;
	localparam int CK_SWCLK = 0;
	localparam int BC_REL = 7;
	localparam int BC_WIDE = 6;
	localparam int BC_AFC = 5;
	localparam int AX_DRV = 0;
	localparam int CNT_W = 5;
	localparam int SYNC_W = 10;

	// ****************************************
	// Reset values and codes
	// ****************************************
	localparam logic [7:0] CTRL_RST = 8'h01;
	localparam logic [7:0] CLKC_RST = 8'h00;
	localparam logic [7:0] CNT_RST = 8'h00;
	localparam logic [15:0] SR_RST = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ZERO = 5'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 5'h01;
	localparam logic [6:0] DIV_ZERO = 7'h00;
	localparam logic [6:0] DIV_ONE = 7'h01;
	localparam logic [2:0] SRC_EXT = 3'h0;
	localparam logic [2:0] SRC_AUX = 3'h1;
	localparam logic [2:0] SRC_SMA = 3'h2;
	localparam logic [2:0] SRC_SMB = 3'h3;
	localparam logic [2:0] SRC_SW = 3'h4;
	localparam logic [2:0] SRC_T0 = 3'h5;
	localparam logic [2:0] SRC_T1 = 3'h6;
	localparam logic [2:0] SRC_T2 = 3'h7;
	localparam resp_t RESP_OKAY = 2'h0;
	localparam resp_t RESP_SLVERR = 2'h2;
	localparam word_t WORD_ZERO = 32'h00000000;
endpackage

// File: rtl/ussc_sync.sv
`timescale 1ns/1ps
// ****************************************
// Two-stage level synchroniser
// ****************************************
module ussc_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;

	// First stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
		end
	end

	assign q = s2_q;
endmodule

// File: rtl/ussc_link.sv
`timescale 1ns/1ps
// ****************************************
// Link-clock edge toggles
// ****************************************
module ussc_link (
	input wire logic link_clk,
	input wire logic aresetn,
	output logic rise_tgl,
	output logic fall_tgl
);
	logic lrst_n;
	logic rise_q;
	logic rise_d;
	logic fall_q;
	logic fall_d;

	// Bring the reset onto the link clock
	ussc_sync #(.W(1)) u_rst (
		.clk(link_clk),
		.rst_n(1'b1),
		.d(aresetn),
		.q(lrst_n)
	);

	// Each link edge flips one toggle
	always_comb begin
		rise_d = ~rise_q;
		fall_d = ~fall_q;
	end

	always_ff @(posedge link_clk) begin
		if (!lrst_n) begin
			rise_q <= 1'b0;
		end else begin
			rise_q <= rise_d;
		end
	end

	always_ff @(negedge link_clk) begin
		if (!lrst_n) begin
			fall_q <= 1'b0;
		end else begin
			fall_q <= fall_d;
		end
	end

	assign rise_tgl = rise_q;
	assign fall_tgl = fall_q;
endmodule

// File: rtl/ussc_top.sv
// Added by the designer: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module ussc_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire ussc_pkg::addr_t awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire ussc_pkg::word_t wdata,
	input wire ussc_pkg::strb_t wstrb,
	input wire logic wvalid,
	output logic wready,
	output ussc_pkg::resp_t bresp,
	output logic bvalid,
	input wire logic bready,
	input wire ussc_pkg::addr_t araddr,
	input wire logic arvalid,
	output logic arready,
	output ussc_pkg::word_t rdata,
	output ussc_pkg::resp_t rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic link_clk,
	input wire logic aux_clk_i,
	input wire logic sub_main_clock_i,
	input wire logic [2:0] timer_cmp_i,
	input wire logic sdi_i,
	output logic sdo_o,
	output logic sdo_oe_n,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n,
	output logic sclk_o,
	output logic irq_o
);
	import ussc_pkg::*;

	// ****************************************
	// Declarations
	// ****************************************
	logic aw_full_q, aw_full_d, w_full_q, w_full_d;
	addr_t aw_addr_q, aw_addr_d;
	word_t w_data_q, w_data_d;
	strb_t w_strb_q, w_strb_d;
	logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
	resp_t bresp_q, bresp_d, rresp_q, rresp_d;
	word_t rdata_q, rdata_d;
	logic wr_en, aw_have, w_have;
	addr_t wr_addr;
	word_t wr_data;
	strb_t wr_strb;
	logic [7:0] ctrl_q, ctrl_d, clkc_q, clkc_d, cnt_q, cnt_d;
	logic [15:0] sr_q, sr_d;
	logic drv_q, drv_d, sdo_q, sdo_d, lvl_q, lvl_d, par_q, par_d;
	logic sclk_q, sclk_d, irq_q, irq_d, hold_q, hold_d;
	logic [6:0] div_q, div_d;
	logic [3:0] hist_q, hist_d;
	logic [SYNC_W-1:0] sync_s;
	logic rt_tgl, ft_tgl, rt_s, ft_s, scl_s, sda_s, sdi_s, aux_s, sub_s;
	logic [2:0] tmr_s;
	logic [2:0] src_code;
	logic src_lvl, src_edge, ext_edge, run, sh_edge, cap, i2c;
	logic start_det, stop_det, arb_hit;

	// Address decode shared by both bus directions
	function automatic logic map_ok(input addr_t a);
		map_ok = (a == OFF_CTRL) || (a == OFF_CLKC) || (a == OFF_CNT) ||
			(a == OFF_SR) || (a == OFF_SRH) || (a == OFF_AUX);
	endfunction

	// Bit presented on the data line for the active width
	function automatic logic shift_msb(input logic [15:0] s, input logic wide);
		shift_msb = wide ? s[15] : s[7];
	endfunction

	// Source edges per shift clock edge, minus one
	function automatic logic [6:0] div_limit(input logic [2:0] code);
		div_limit = 7'((8'h01 << code) - 8'h01);
	endfunction

	// ****************************************
	// Crossings
	// ****************************************
	ussc_link u_link (
		.link_clk(link_clk),
		.aresetn(aresetn),
		.rise_tgl(rt_tgl),
		.fall_tgl(ft_tgl)
	);

	ussc_sync #(.W(SYNC_W)) u_sync (
		.clk(aclk),
		.rst_n(aresetn),
		.d({timer_cmp_i, aux_clk_i, sub_main_clock_i, sdi_i, sda_i, scl_i, rt_tgl, ft_tgl}),
		.q(sync_s)
	);
	assign {tmr_s, aux_s, sub_s, sdi_s, sda_s, scl_s, rt_s, ft_s} = sync_s;

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign awready = !aw_full_q && !bvalid_q;
	assign wready = !w_full_q && !bvalid_q;
	assign arready = !rvalid_q;
	assign aw_have = aw_full_q || (awvalid && awready);
	assign w_have = w_full_q || (wvalid && wready);
	assign wr_en = aw_have && w_have && !bvalid_q;
	assign wr_addr = aw_full_q ? aw_addr_q : awaddr;
	assign wr_data = w_full_q ? w_data_q : wdata;
	assign wr_strb = w_full_q ? w_strb_q : wstrb;

	// Channel holding, write answer and read answer
	always_comb begin
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d = w_full_q;
		w_data_d = w_data_q;
		w_strb_d = w_strb_q;
		bvalid_d = bvalid_q && !bready;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q && !rready;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (awvalid && awready) begin
			aw_full_d = 1'b1;
			aw_addr_d = awaddr;
		end
		if (wvalid && wready) begin
			w_full_d = 1'b1;
			w_data_d = wdata;
			w_strb_d = wstrb;
		end
		if (wr_en) begin
			aw_full_d = 1'b0;
			w_full_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = map_ok(wr_addr) ? RESP_OKAY : RESP_SLVERR;
		end
		if (arvalid && arready) begin
			rvalid_d = 1'b1;
			rresp_d = map_ok(araddr) ? RESP_OKAY : RESP_SLVERR;
			rdata_d = WORD_ZERO;
			case (araddr)
				OFF_CTRL: rdata_d[7:0] = ctrl_q;
				OFF_CLKC: rdata_d[7:0] = clkc_q;
				OFF_CNT: rdata_d[7:0] = cnt_q;
				OFF_SR: rdata_d[15:0] = cnt_q[BC_WIDE] ? sr_q : {8'h00, sr_q[7:0]}; // see R8
				OFF_SRH: rdata_d[7:0] = sr_q[15:8];
				OFF_AUX: rdata_d[AX_DRV] = drv_q;
				default: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= OFF_CTRL;
			w_full_q <= 1'b0;
			w_data_q <= WORD_ZERO;
			w_strb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= WORD_ZERO;
		end else begin
			aw_full_q <= aw_full_d;
			aw_addr_q <= aw_addr_d;
			w_full_q <= w_full_d;
			w_data_q <= w_data_d;
			w_strb_q <= w_strb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign rvalid = rvalid_q;
	assign rresp = rresp_q;
	assign rdata = rdata_q;

	// ****************************************
	// Clock source, divider and bus events
	// ****************************************
	assign i2c = ctrl_q[CF_I2C]; // see R2
	assign src_code = clkc_q[CK_SEL_LSB+2:CK_SEL_LSB];
	assign ext_edge = i2c && ((rt_s != hist_q[2]) || (ft_s != hist_q[1]));

	// Source level selection
	always_comb begin
		unique case (src_code) // see R16
			SRC_EXT: src_lvl = 1'b0;
			SRC_AUX: src_lvl = aux_s;
			SRC_SMA: src_lvl = sub_s;
			SRC_SMB: src_lvl = sub_s;
			SRC_SW: src_lvl = clkc_q[CK_SWCLK];
			SRC_T0: src_lvl = tmr_s[0];
			SRC_T1: src_lvl = tmr_s[1];
			SRC_T2: src_lvl = tmr_s[2];
		endcase
	end

	assign src_edge = (src_code == SRC_EXT) ? ext_edge : (src_lvl != hist_q[0]); // see R16
	assign run = cnt_q[CNT_W-1:0] != CNT_ZERO;
	assign sh_edge = run && src_edge && (div_q == div_limit(clkc_q[CK_DIV_LSB+2:CK_DIV_LSB])); // see R15
	assign cap = sh_edge && (par_q ^ ctrl_q[CF_PHASE]); // see R1
	assign start_det = i2c && scl_s && hist_q[3] && !sda_s; // see R2
	assign stop_det = i2c && scl_s && !hist_q[3] && sda_s;
	assign arb_hit = cap && i2c && drv_q && sdo_q && !sda_s; // see R5

	// ****************************************
	// Registers and shift engine
	// ****************************************
	always_comb begin
		ctrl_d = ctrl_q;
		clkc_d = clkc_q;
		cnt_d = cnt_q;
		sr_d = sr_q;
		drv_d = drv_q;
		sdo_d = sdo_q;
		lvl_d = lvl_q;
		par_d = par_q;
		div_d = div_q;
		hist_d = {sda_s, rt_s, ft_s, src_lvl};
		// Software writes first, hardware events override them
		if (wr_en && wr_strb[0]) begin
			case (wr_addr)
				OFF_CTRL: ctrl_d = wr_data[7:0];
				OFF_CLKC: clkc_d = wr_data[7:0];
				OFF_CNT: begin
					cnt_d = wr_data[7:0];
					if (cnt_d[CNT_W-1:0] == CNT_ZERO) begin
						ctrl_d[CF_IFG] = 1'b1; // see R11
					end else if (!cnt_d[BC_AFC]) begin
						ctrl_d[CF_IFG] = 1'b0; // see R9
						ctrl_d[CF_STP] = 1'b0; // see R6
					end
				end
				OFF_SR: sr_d[7:0] = wr_data[7:0];
				OFF_SRH: sr_d[15:8] = wr_data[7:0];
				OFF_AUX: drv_d = wr_data[AX_DRV];
				default: ;
			endcase
		end
		if (wr_en && wr_strb[1] && (wr_addr == OFF_SR)) begin
			sr_d[15:8] = wr_data[15:8]; // see R8
		end
		if (!run) begin
			sdo_d = shift_msb(sr_d, cnt_d[BC_WIDE]);
		end
		// Idle: clock rests, edge parity restarts
		if (!run) begin
			lvl_d = 1'b0;
			par_d = 1'b0;
			div_d = DIV_ZERO;
		end else if (src_edge) begin
			div_d = sh_edge ? DIV_ZERO : div_q + DIV_ONE; // see R15
		end
		if (sh_edge) begin
			lvl_d = ~lvl_q;
			par_d = ~par_q;
			if (cap) begin
				sr_d = cnt_q[BC_WIDE] ? {sr_q[14:0], sdi_s} : {sr_q[15:8], sr_q[6:0], sdi_s}; // see R8
				cnt_d[CNT_W-1:0] = cnt_q[CNT_W-1:0] - CNT_ONE; // see R10
				if (cnt_d[CNT_W-1:0] == CNT_ZERO) begin
					ctrl_d[CF_IFG] = 1'b1; // see R11
				end
			end else begin
				sdo_d = shift_msb(sr_q, cnt_q[BC_WIDE]); // see R1
			end
		end
		if (arb_hit) begin
			ctrl_d[CF_AL] = 1'b1; // see R5
			drv_d = 1'b0; // see R13
		end
		if (start_det) begin
			ctrl_d[CF_STT] = 1'b1; // see R12
			cnt_d[BC_REL] = 1'b0; // see R14
		end
		if (stop_det) begin
			ctrl_d[CF_STP] = 1'b1; // see R6
		end
		sclk_d = clkc_d[CK_POL] ^ lvl_d; // see R7
		irq_d = (ctrl_d[CF_STT] && ctrl_d[CF_STTIE]) || (ctrl_d[CF_IFG] && ctrl_d[CF_IE]); // see R3 R4
		hold_d = ctrl_d[CF_I2C] && !cnt_d[BC_REL] && // see R14
			(ctrl_d[CF_IFG] || ctrl_d[CF_STT] || (cnt_d[CNT_W-1:0] == CNT_ZERO));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= CTRL_RST;
			clkc_q <= CLKC_RST;
			cnt_q <= CNT_RST;
			sr_q <= SR_RST;
			drv_q <= 1'b0;
			sdo_q <= 1'b0;
			lvl_q <= 1'b0;
			par_q <= 1'b0;
			div_q <= DIV_ZERO;
			hist_q <= 4'h0;
			sclk_q <= 1'b0;
			irq_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			ctrl_q <= ctrl_d;
			clkc_q <= clkc_d;
			cnt_q <= cnt_d;
			sr_q <= sr_d;
			drv_q <= drv_d;
			sdo_q <= sdo_d;
			lvl_q <= lvl_d;
			par_q <= par_d;
			div_q <= div_d;
			hist_q <= hist_d;
			sclk_q <= sclk_d;
			irq_q <= irq_d;
			hold_q <= hold_d;
		end
	end

	// Pin drive; open-drain lines only ever pull low
	assign sdo_o = sdo_q;
	assign sdo_oe_n = !(drv_q && !i2c);
	assign sda_o = 1'b0;
	assign sda_oe_n = !(i2c && drv_q && !sdo_q); // see R13
	assign scl_o = 1'b0;
	assign scl_oe_n = !hold_q; // see R14
	assign sclk_o = sclk_q;
	assign irq_o = irq_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_irq_start: assert property (ctrl_q[CF_STT] && ctrl_q[CF_STTIE] |-> irq_o) // see R3
		else $error("start flag enabled but no request");
	chk_irq_quiet: assert property (!ctrl_q[CF_STTIE] && !ctrl_q[CF_IE] |-> !irq_o) // see R4
		else $error("request raised with both enables low");
	chk_irq_count: assert property (ctrl_q[CF_IFG] && ctrl_q[CF_IE] |-> irq_o) // see R4
		else $error("count flag enabled but no request");
	chk_count_done: assert property (run ##1 !run |-> ctrl_q[CF_IFG]) // see R11
		else $error("count reached zero without flag");
	chk_start_set: assert property (start_det |=> ctrl_q[CF_STT] && !cnt_q[BC_REL]) // see R12
		else $error("start not flagged or release kept");
	chk_stop_set: assert property (stop_det |=> ctrl_q[CF_STP]) // see R6
		else $error("stop not flagged");
	chk_arb_drop: assert property (arb_hit |=> ctrl_q[CF_AL] && !drv_q && sda_oe_n) // see R13
		else $error("arbitration loss not handled");
	chk_idle_level: assert property (!run |=> sclk_o == clkc_q[CK_POL]) // see R7
		else $error("idle clock level wrong");
	chk_auto_clear: assert property (wr_en && wr_strb[0] && wr_addr == OFF_CNT &&
		wr_data[CNT_W-1:0] != CNT_ZERO && !wr_data[BC_AFC] && !sh_edge && !stop_det
		|=> !ctrl_q[CF_IFG] && !ctrl_q[CF_STP]) // see R9
		else $error("flags not cleared on count load");
	chk_flag_keep: assert property (wr_en && wr_strb[0] && wr_addr == OFF_CNT &&
		wr_data[BC_AFC] && ctrl_q[CF_IFG] |=> ctrl_q[CF_IFG]) // see R9
		else $error("flag cleared despite control bit");
	chk_phase_hold: assert property (sh_edge && !cap && !wr_en |=> $stable(cnt_q)) // see R1
		else $error("count moved on a change edge");
	chk_narrow_keep: assert property (cap && !cnt_q[BC_WIDE] && !wr_en |=> $stable(sr_q[15:8])) // see R8
		else $error("high byte shifted in narrow mode");
	chk_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped early");

	cov_transfer_done: cover property (run ##[1:1000] !run);
	cov_start_seen: cover property (start_det);
	cov_arb_lost: cover property (arb_hit);
endmodule

// File: bench/ussc_peer.sv
`timescale 1ns/1ps
// ****************************************
// Serial bus peer: shifts on the device clock, drives the link clock
// ****************************************
module ussc_peer (
	input wire logic sclk_o,
	input wire logic sdo_o,
	output logic sdi,
	output logic link_clk,
	output logic scl_drv,
	output logic sda_drv
);
	logic act, lk, ph, bit_q;
	logic [15:0] tx, rx;
	int k, nb, j;
	// Between frames the data line shows the inverse of its last bit
	assign sdi = (act || lk) ? bit_q : ~bit_q;
	// Idle bus with both open-drain lines released
	initial begin
		act = 1'b0;
		lk = 1'b0;
		ph = 1'b0;
		bit_q = 1'b0;
		tx = 16'h0000;
		rx = 16'h0000;
		k = 0;
		nb = 8;
		link_clk = 1'b0;
		scl_drv = 1'b1;
		sda_drv = 1'b1;
		// Run the link clock through reset so the link side starts known
		repeat (100) #15 link_clk = ~link_clk;
	end
	// Arm a frame; capture-first mode needs the first bit before any edge
	task automatic open(input logic p, input logic [15:0] t, input int n);
		ph = p;
		tx = t;
		nb = n;
		k = 0;
		rx = 16'h0000;
		bit_q = t[n-1];
		act = 1'b1;
	endtask
	task automatic close();
		act = 1'b0;
	endtask
	// Capture or change on each device clock edge, by edge parity and phase
	always @(sclk_o) begin
		if (act) begin
			j = (k + ph) / 2;
			if (k[0] ^ ph) begin
				rx = {rx[14:0], sdo_o};
			end else if (j < nb) begin
				bit_q = tx[nb-1-j];
			end
			k++;
		end
	end
	// Data line level change with the clock line released
	task automatic cond(input logic v);
		sda_drv = v;
		#400;
	endtask
	// One byte on the link clock, data changed while the clock line is low
	task automatic link_byte(input logic [7:0] b);
		lk = 1'b1;
		scl_drv = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			bit_q = b[i];
			sda_drv = b[i];
			// Wide high phase keeps rise and fall in separate bus cycles
			#80 link_clk = 1'b1;
			#120 link_clk = 1'b0;
			#215;
		end
		lk = 1'b0;
		sda_drv = 1'b1;
		#80 scl_drv = 1'b1;
	endtask
endmodule

// File: bench/universal_serial_shift_ctrl_tb_top.sv
`timescale 1ns/1ps
module universal_serial_shift_ctrl_tb_top;
	import ussc_pkg::*;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
	addr_t awaddr, araddr;
	word_t wdata, rdata;
	strb_t wstrb;
	resp_t bresp, rresp, exp_b;
	logic sdi, link_clk, scl_drv, sda_drv, sdo_o, sdo_oe_n, sda_o, sda_oe_n, scl_o, scl_oe_n, sclk_o, irq_o;
	logic sda_line, scl_line, sclk_p;
	logic [4:0] src_q;
	logic [2:0] cyc_q;
	logic [2:0] srcs[6];
	logic [31:0] seed;
	logic [33:0] exp_r;
	logic [33:0] rq[$];
	resp_t wq[$];
	logic [7:0] b;
	int err_total, check_count, gap, gap_last;
	// ****************************************
	// Clock, open-drain lines, instances
	// ****************************************
	always #20 aclk = ~aclk;
	assign sda_line = sda_drv & (sda_oe_n | sda_o);
	assign scl_line = scl_drv & (scl_oe_n | scl_o);
	ussc_top DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
		.bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .link_clk(link_clk), .aux_clk_i(src_q[0]),
		.sub_main_clock_i(src_q[1]), .timer_cmp_i(src_q[4:2]), .sdi_i(sdi), .sdo_o(sdo_o),
		.sdo_oe_n(sdo_oe_n), .sda_i(sda_line), .sda_o(sda_o), .sda_oe_n(sda_oe_n), .scl_i(scl_line),
		.scl_o(scl_o), .scl_oe_n(scl_oe_n), .sclk_o(sclk_o), .irq_o(irq_o));
	ussc_peer peer (.sclk_o(sclk_o), .sdo_o(sdo_o), .sdi(sdi), .link_clk(link_clk), .scl_drv(scl_drv),
		.sda_drv(sda_drv));
	// Source clocks toggle every 8 cycles; shift clock spacing is measured
	always @(posedge aclk) begin
		cyc_q <= cyc_q + 3'h1;
		if (cyc_q == 3'h7) src_q <= ~src_q;
		sclk_p <= sclk_o;
		// A return to idle one cycle after the last edge is not a spacing
		if (sclk_o != sclk_p) begin
			if (gap > 1) gap_last <= gap;
			gap <= 1;
		end else gap <= gap + 1;
	end
	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [15:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[15:0];
	endfunction
	task automatic print_verdict();
		if (err_total == 0 && check_count > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	// Bus write: address and data offered together, each released when taken
	// Waits for the answer; only the watchdog ends a hung wait
	task automatic wr(input addr_t a, input logic [15:0] d, input resp_t r = RESP_OKAY);
		wq.push_back(r);
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= 4'hf;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) bready <= 1'b0;
		end while (!bvalid);
		// Let an edge pass before the next request
		@(posedge aclk);
	endtask
	task automatic rd(input addr_t a, input logic [15:0] e, input resp_t r = RESP_OKAY);
		rq.push_back({r, 16'h0000, e});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) rready <= 1'b0;
		end while (!rvalid);
		@(posedge aclk);
	endtask
	// Responses are matched against the oldest expectation
	always @(posedge aclk) begin
		if (rvalid && rready && rq.size() > 0) begin
			exp_r = rq.pop_front();
			check_count++;
			if ({rresp, rdata} !== exp_r) begin
				err_total++;
				$display("unexpected at %0t: read %h want %h", $time, {rresp, rdata}, exp_r);
			end
		end
		if (bvalid && bready && wq.size() > 0) begin
			exp_b = wq.pop_front();
			check_count++;
			if (bresp !== exp_b) begin
				err_total++;
				$display("unexpected at %0t: write response %h want %h", $time, bresp, exp_b);
			end
		end
	end
	// One shift transfer against the peer, mode chosen by case number
	task automatic xfer(input int i);
		logic ph, pl, wd;
		logic [2:0] dv;
		logic [15:0] d, t, m;
		int nb;
		ph = i[0];
		pl = i[1];
		wd = i > 3;
		dv = 3'(i % 3);
		nb = wd ? 16 : 8;
		m = wd ? 16'hffff : 16'h00ff;
		t = rnd() & m;
		d = rnd() & m;
		wr(OFF_CTRL, {8'h00, ph, 7'h10});
		wr(OFF_AUX, 16'h0001);
		wr(OFF_CLKC, {8'h00, dv, srcs[i], pl, 1'b0});
		repeat (4) @(posedge aclk);
		chk(16'(sclk_o), 16'(pl));
		wr(OFF_SR, d);
		peer.open(ph, t, nb);
		wr(OFF_CNT, {9'h000, wd, 1'b0, 5'(nb)});
		while (irq_o !== 1'b1) @(posedge aclk);
		peer.close();
		rd(OFF_SR, t);
		chk(peer.rx & m, d);
		chk(16'(gap_last), 16'(8 << dv));
		rd(OFF_CNT, {9'h000, wd, 6'h00});
	endtask
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sclk_p} = 8'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		{cyc_q, src_q, err_total, check_count, gap, gap_last} = 0;
		seed = 32'h00007e35;
		srcs = '{SRC_AUX, SRC_SMA, SRC_SMB, SRC_T0, SRC_T1, SRC_T2};
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(OFF_CTRL, 16'h0001);
		rd(OFF_CLKC, 16'h0000);
		rd(OFF_CNT, 16'h0000);
		rd(8'h18, 16'h0000, RESP_SLVERR);
		wr(8'h18, 16'h00ff, RESP_SLVERR);
		wr(OFF_SR, 16'h5aa5);
		rd(OFF_SRH, 16'h005a);
		for (int i = 0; i < 6; i++) xfer(i);
		// Completion flag, its interrupt gate and automatic clearing
		wr(OFF_CLKC, 16'h0010);
		wr(OFF_CTRL, 16'h0010);
		wr(OFF_CNT, 16'h0000);
		repeat (3) @(posedge aclk);
		chk(16'(irq_o), 16'h0001);
		wr(OFF_CNT, 16'h0023);
		rd(OFF_CTRL, 16'h0011);
		wr(OFF_CNT, 16'h0003);
		rd(OFF_CTRL, 16'h0010);
		wr(OFF_CTRL, 16'h0000);
		wr(OFF_CNT, 16'h0001);
		wr(OFF_CLKC, 16'h0011);
		wr(OFF_CLKC, 16'h0010);
		repeat (6) @(posedge aclk);
		rd(OFF_CTRL, 16'h0001);
		chk(16'(irq_o), 16'h0000);
		// Two-wire conditions, clock holding and release
		wr(OFF_AUX, 16'h0000);
		wr(OFF_CTRL, 16'h0040);
		wr(OFF_CNT, 16'h0081);
		peer.cond(1'b0);
		@(posedge aclk);
		chk(16'(irq_o), 16'h0000);
		chk(16'(scl_oe_n), 16'h0000);
		rd(OFF_CNT, 16'h0001);
		rd(OFF_CTRL, 16'h0042);
		wr(OFF_CTRL, 16'h0062);
		repeat (3) @(posedge aclk);
		chk(16'(irq_o), 16'h0001);
		wr(OFF_CNT, 16'h0081);
		repeat (3) @(posedge aclk);
		chk(16'(scl_oe_n), 16'h0001);
		peer.cond(1'b1);
		@(posedge aclk);
		rd(OFF_CTRL, 16'h0066);
		wr(OFF_CNT, 16'h0082);
		rd(OFF_CTRL, 16'h0062);
		// Byte clocked in on the external link clock
		wr(OFF_CTRL, 16'h0040);
		wr(OFF_CLKC, 16'h0000);
		wr(OFF_CNT, 16'h0088);
		b = 8'(rnd());
		peer.link_byte(b);
		@(posedge aclk);
		rd(OFF_SR, {8'h00, b});
		rd(OFF_CTRL, 16'h0041);
		print_verdict();
	end
	// Watchdog against a hung handshake or transfer
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		print_verdict();
	end
endmodule
